// *** verilog/cmb_mailbox.sv ***
`timescale 1ns/100ps
`include "cmb_params.svh"
// Contract
// - overrun policy, full reception mailbox: drop frame, set lost flag, overrun irq if enabled
// - extended-id bit counts only in mixed id format; else software keeps it zero
// - one-shot mailbox never flags loss and takes no frame until complete flag clears
// - clearing request, complete and lost together aborts reception
// - arrangement select zero: all 64 mailboxes are normal
// - arrangement select one: 0-55 normal, 56-59 tx queue, 60-63 rx queue
// - writes go through mailbox 56, reads through 60; key ff advances pointers
// - bit 24 enables tx queue irq; bit 25 chooses every completion or empty
// - bit 28 enables rx queue irq; bit 29 chooses every reception or warning
// - queue mode ignores message control of mailboxes 56-63
// - tx queue runs only while its enable is one
// - enable cleared mid-send flushes queue at next completion, error or halt
// - tx queue holds four; empty and full status
// - rx queue runs only while its enable is one
// - rx queue empty at zero, warning at three, full at four
// - frame into full rx queue sets lost flag; drop or overwrite oldest
// - rx queue accepts ids matching a compare register under a queue mask
// - tx queue abort by clearing enable; empty status marks completion
// - overrun policy never changes the rx queue entry being read
// - overwrite policy replaces message, sets complete, sets lost if already complete
// - one-shot frames go to lowest matching mailbox without unprocessed message
module cmb_mailbox #(
   parameter int NMB = `CMB_NMB
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire cmb_pkg::cmb_frame_t rx_frame,
   input wire logic tx_busy,
   input wire logic tx_done,
   input wire logic tx_abandon,
   input wire logic halt_enter,
   output logic tx_valid,
   output cmb_pkg::cmb_frame_t tx_frame,
   output logic overrun_irq,
   output logic txq_irq,
   output logic rxq_irq
);
   localparam int IW = $clog2(NMB);
   localparam int FW = $bits(cmb_pkg::cmb_frame_t);

   // queue positions are fixed at 56..63, so only a 64-entry array fits
   if (NMB != 64) begin : g_bad_nmb
      $error("mailbox count must be 64");
   end

   function automatic logic masked_eq(input logic [28:0] id, input logic [28:0] cmp, input logic [28:0] msk);
      return ((id ^ cmp) & msk) == 29'h0;
   endfunction

   function automatic logic id_eq(input cmb_pkg::cmb_frame_t a, input cmb_pkg::cmb_frame_t b,
                                  input logic mixed);
      // extended bit only counts in mixed format
      return (a.id == b.id) && (!mixed || a.ide == b.ide);
   endfunction

   // channel and queue registers
   logic arr_q;
   logic lmode_q;
   logic [1:0] idf_q;
   logic ovr_ie_q;
   logic [31:0] mier_q;
   logic [IW-1:0] sel_q;
   logic txq_en_q;
   logic rxq_en_q;
   logic rxq_lost_q;
   logic flush_pend_q;
   logic [28:0] mska_q;
   logic [28:0] mskb_q;
   logic [28:0] cmpa_q;
   logic [28:0] cmpb_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic tx_valid_q;
   cmb_pkg::cmb_frame_t tx_frame_q;
   logic ovr_irq_q;
   logic txq_irq_q;
   logic rxq_irq_q;

   // per-mailbox state, gathered from the generate below
   wire [NMB-1:0] rxreq;
   wire [NMB-1:0] once;
   wire [NMB-1:0] newd;
   wire [NMB-1:0] lost;
   wire [NMB-1:0] cand;
   wire cmb_pkg::cmb_frame_t mb_fr [NMB];

   // bus decode
   logic acc;
   logic wr_en;
   logic rd_ph;
   logic key_ok;
   logic sel_lock;
   logic sel_stage;
   logic sel_head;
   logic w_ctl;
   logic w_mier;
   logic w_sel;
   logic w_mctl;
   logic w_mid;
   logic w_mdlo;
   logic w_mdhi;
   logic w_txc;
   logic w_rxc;
   logic w_txp;
   logic w_rxp;
   logic [31:0] rd_word;
   logic rd_ok;

   assign acc = psel & penable & pready_q;
   assign wr_en = acc & pwrite;
   assign rd_ph = psel & penable & ~pready_q;
   assign key_ok = pwdata[7:0] == `CMB_ADV_KEY;
   assign sel_lock = arr_q & (sel_q >= `CMB_TXQ_BASE);
   assign sel_stage = arr_q & (sel_q == `CMB_TXQ_BASE);
   assign sel_head = arr_q & (sel_q == `CMB_RXQ_BASE);
   assign w_ctl = wr_en & (paddr == `CMB_OFF_CTL);
   assign w_mier = wr_en & (paddr == `CMB_OFF_MIER);
   assign w_sel = wr_en & (paddr == `CMB_OFF_SEL);
   assign w_mctl = wr_en & (paddr == `CMB_OFF_MCTL) & ~sel_lock;
   assign w_mid = wr_en & (paddr == `CMB_OFF_MID) & (~sel_lock | sel_stage);
   assign w_mdlo = wr_en & (paddr == `CMB_OFF_MDLO) & (~sel_lock | sel_stage);
   assign w_mdhi = wr_en & (paddr == `CMB_OFF_MDHI) & (~sel_lock | sel_stage);
   assign w_txc = wr_en & (paddr == `CMB_OFF_TXQC);
   assign w_rxc = wr_en & (paddr == `CMB_OFF_RXQC);
   assign w_txp = wr_en & (paddr == `CMB_OFF_TXPC) & key_ok;
   assign w_rxp = wr_en & (paddr == `CMB_OFF_RXPC) & key_ok;

   // receive search over the mailbox array
   logic mixed;
   logic lim_ok;
   logic mb_hit;
   logic [IW-1:0] mb_idx;
   logic hit_once;
   logic hit_full;
   logic mb_drop;
   logic mb_store;
   logic mb_lose;

   assign mixed = idf_q == `CMB_IDF_MIXED;

   always_comb begin
      mb_hit = 1'b0;
      mb_idx = '0;
      for (int j = NMB - 1; j >= 0; j--) begin
         if (cand[j]) begin
            mb_hit = 1'b1;
            mb_idx = IW'(j);
         end
      end
   end

   assign hit_once = once[mb_idx];
   assign hit_full = newd[mb_idx];
   // one-shot boxes never reach here while full, so loss is never seen on them
   assign mb_drop = mb_hit & ~hit_once & lmode_q & hit_full;
   assign mb_store = mb_hit & ~mb_drop;
   assign mb_lose = mb_hit & ~hit_once & hit_full;

   for (genvar j = 0; j < NMB; j++) begin : g_mb
      logic rr_q;
      logic os_q;
      logic nd_q;
      logic ml_q;
      cmb_pkg::cmb_frame_t fr_q;
      logic wsel;
      logic rset;
      logic in_range;

      assign wsel = sel_q == IW'(j);
      assign rset = mb_store & (mb_idx == IW'(j));
      // queue slots stay out of the normal search
      assign in_range = ~arr_q | (IW'(j) < `CMB_TXQ_BASE);
      assign cand[j] = rx_valid & rr_q & in_range & id_eq(fr_q, rx_frame, mixed)
                       & ~(os_q & nd_q);
      assign rxreq[j] = rr_q;
      assign once[j] = os_q;
      assign newd[j] = nd_q;
      assign lost[j] = ml_q;
      assign mb_fr[j] = fr_q;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rr_q <= 1'b0;
            os_q <= 1'b0;
            nd_q <= 1'b0;
            ml_q <= 1'b0;
         end else begin
            if (w_mctl && wsel) begin
               // request and single-use land in the same write
               rr_q <= pwdata[`CMB_MC_RXREQ];
               os_q <= pwdata[`CMB_MC_ONCE];
            end
            // a hardware set beats a same-cycle software clear
            nd_q <= rset | (nd_q & ~(w_mctl & wsel & ~pwdata[`CMB_MC_NEWD]));
            ml_q <= (mb_lose && mb_idx == IW'(j)) | (ml_q & ~(w_mctl & wsel & ~pwdata[`CMB_MC_LOST]));
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            fr_q <= '0;
         end else if (rset) begin
            fr_q <= rx_frame;
         end else if (wsel) begin
            if (w_mid) begin
               fr_q.ide <= pwdata[`CMB_MID_IDE];
               fr_q.id <= pwdata[28:0];
            end
            if (w_mdlo) begin
               fr_q.data[31:0] <= pwdata;
            end
            if (w_mdhi) begin
               fr_q.data[63:32] <= pwdata;
            end
         end
      end
   end

   // receive queue
   logic q_match;
   logic rxq_take;
   logic rxq_full;
   logic rxq_push;
   logic rxq_pop;
   logic [2:0] rxq_cnt;
   cmb_pkg::cmb_frame_t rxq_head;

   assign q_match = masked_eq(rx_frame.id, cmpa_q, mska_q) | masked_eq(rx_frame.id, cmpa_q, mskb_q)
                    | masked_eq(rx_frame.id, cmpb_q, mska_q) | masked_eq(rx_frame.id, cmpb_q, mskb_q);
   assign rxq_take = rx_valid & ~mb_hit & arr_q & rxq_en_q & q_match;
   assign rxq_full = rxq_cnt == `CMB_QFULL;
   // overrun leaves the head alone; overwrite pushes and retires the oldest
   assign rxq_push = rxq_take & ~(rxq_full & lmode_q);
   assign rxq_pop = w_rxp & arr_q & rxq_en_q;

   cmb_queue #(
      .W(FW),
      .DEPTH(`CMB_QDEPTH)
   ) u_rxq (
      .pclk(pclk),
      .presetn(presetn),
      .push(rxq_push),
      .pop(rxq_pop),
      .flush(1'b0),
      .wdata(rx_frame),
      .rdata(rxq_head),
      .count(rxq_cnt)
   );

   // transmit queue
   logic txq_push;
   logic txq_pop;
   logic txq_flush;
   logic txq_end;
   logic [2:0] txq_cnt;
   cmb_pkg::cmb_frame_t txq_head;

   assign txq_push = w_txp & arr_q & txq_en_q & (txq_cnt != `CMB_QFULL);
   assign txq_pop = tx_done & tx_valid_q;
   assign txq_end = tx_done | tx_abandon | halt_enter;
   // idle queue empties at once; a frame on the wire is let finish first
   assign txq_flush = (w_txc & ~pwdata[`CMB_QC_EN] & ~tx_busy)
                      | (flush_pend_q & txq_end);

   cmb_queue #(
      .W(FW),
      .DEPTH(`CMB_QDEPTH)
   ) u_txq (
      .pclk(pclk),
      .presetn(presetn),
      .push(txq_push),
      .pop(txq_pop),
      .flush(txq_flush),
      .wdata(mb_fr[`CMB_TXQ_BASE]),
      .rdata(txq_head),
      .count(txq_cnt)
   );

   // register read mux
   cmb_pkg::cmb_frame_t sel_fr;
   assign sel_fr = sel_head ? rxq_head : mb_fr[sel_q];

   always_comb begin
      rd_word = 32'h0;
      rd_ok = 1'b1;
      case (paddr)
         `CMB_OFF_CTL: rd_word = {27'h0, ovr_ie_q, idf_q, lmode_q, arr_q};
         `CMB_OFF_MIER: rd_word = mier_q;
         `CMB_OFF_SEL: rd_word = 32'(sel_q);
         `CMB_OFF_MCTL: rd_word = sel_lock ? 32'h0 :
            {25'h0, rxreq[sel_q], once[sel_q], 3'h0, lost[sel_q], newd[sel_q]};
         `CMB_OFF_MID: rd_word = {sel_fr.ide, 2'h0, sel_fr.id};
         `CMB_OFF_MDLO: rd_word = sel_fr.data[31:0];
         `CMB_OFF_MDHI: rd_word = sel_fr.data[63:32];
         `CMB_OFF_TXQC: rd_word = {29'h0, txq_cnt == `CMB_QFULL, txq_cnt == 3'h0, txq_en_q};
         `CMB_OFF_RXQC: rd_word = {27'h0, rxq_lost_q, rxq_full, rxq_cnt == `CMB_QWARN,
                                   rxq_cnt == 3'h0, rxq_en_q};
         `CMB_OFF_TXPC: rd_word = 32'h0;
         `CMB_OFF_RXPC: rd_word = 32'h0;
         `CMB_OFF_MSKA: rd_word = {3'h0, mska_q};
         `CMB_OFF_MSKB: rd_word = {3'h0, mskb_q};
         `CMB_OFF_CMPA: rd_word = {3'h0, cmpa_q};
         `CMB_OFF_CMPB: rd_word = {3'h0, cmpb_q};
         default: rd_ok = 1'b0;
      endcase
   end

   // one wait state so that read data leaves a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         pready_q <= rd_ph;
         pslverr_q <= rd_ph & ~rd_ok;
         prdata_q <= (rd_ph & ~pwrite & rd_ok) ? rd_word : 32'h0;
      end
   end

   // channel configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_q <= 1'b0;
         lmode_q <= 1'b0;
         idf_q <= 2'h0;
         ovr_ie_q <= 1'b0;
         mier_q <= `CMB_RST_MIER;
         sel_q <= '0;
      end else begin
         if (w_ctl) begin
            arr_q <= pwdata[`CMB_CTL_ARR];
            lmode_q <= pwdata[`CMB_CTL_LMODE];
            idf_q <= pwdata[`CMB_CTL_IDF];
            ovr_ie_q <= pwdata[`CMB_CTL_OVRIE];
         end
         if (w_mier) begin
            mier_q <= pwdata & `CMB_MIE_MASK;
         end
         if (w_sel) begin
            sel_q <= pwdata[IW-1:0];
         end
      end
   end

   // queue control and filters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txq_en_q <= 1'b0;
         rxq_en_q <= 1'b0;
         rxq_lost_q <= 1'b0;
         flush_pend_q <= 1'b0;
         mska_q <= `CMB_RST_MASK;
         mskb_q <= `CMB_RST_MASK;
         cmpa_q <= 29'h0;
         cmpb_q <= 29'h0;
      end else begin
         if (w_txc) begin
            txq_en_q <= pwdata[`CMB_QC_EN];
         end
         if (w_rxc) begin
            rxq_en_q <= pwdata[`CMB_QC_EN];
         end
         rxq_lost_q <= (rxq_take & rxq_full) | (rxq_lost_q & ~(w_rxc & ~pwdata[`CMB_RQC_LOST]));
         flush_pend_q <= (w_txc & ~pwdata[`CMB_QC_EN] & tx_busy) | (flush_pend_q & ~txq_end);
         if (wr_en && paddr == `CMB_OFF_MSKA) begin
            mska_q <= pwdata[28:0];
         end
         if (wr_en && paddr == `CMB_OFF_MSKB) begin
            mskb_q <= pwdata[28:0];
         end
         if (wr_en && paddr == `CMB_OFF_CMPA) begin
            cmpa_q <= pwdata[28:0];
         end
         if (wr_en && paddr == `CMB_OFF_CMPB) begin
            cmpb_q <= pwdata[28:0];
         end
      end
   end

   // engine side and interrupt pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_valid_q <= 1'b0;
         tx_frame_q <= '0;
         ovr_irq_q <= 1'b0;
         txq_irq_q <= 1'b0;
         rxq_irq_q <= 1'b0;
      end else begin
         // valid drops for a cycle after each completion so a stale head is never offered
         tx_valid_q <= arr_q & txq_en_q & (txq_cnt != 3'h0) & ~txq_pop & ~txq_flush & ~flush_pend_q;
         tx_frame_q <= txq_head;
         ovr_irq_q <= ovr_ie_q & (mb_drop | (rxq_take & rxq_full & lmode_q));
         txq_irq_q <= mier_q[`CMB_MIE_TXQ_IE] & txq_pop
                      & (~mier_q[`CMB_MIE_TXQ_EMPTY] | txq_cnt == `CMB_QONE);
         // a pop back down from full is not a push, so it never fires here
         rxq_irq_q <= mier_q[`CMB_MIE_RXQ_IE] & rxq_push
                      & (~mier_q[`CMB_MIE_RXQ_WARN] | (rxq_cnt == `CMB_QLOW & ~rxq_pop));
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_valid = tx_valid_q;
   assign tx_frame = tx_frame_q;
   assign overrun_irq = ovr_irq_q;
   assign txq_irq = txq_irq_q;
   assign rxq_irq = rxq_irq_q;
endmodule // cmb_mailbox

// *** verilog/cmb_params.svh ***
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

`define CMB_NMB 64
`define CMB_QDEPTH 4
`define CMB_TXQ_BASE 6'h38
`define CMB_RXQ_BASE 6'h3c
`define CMB_QFULL 3'h4
`define CMB_QWARN 3'h3
`define CMB_QLOW 3'h2
`define CMB_QONE 3'h1
`define CMB_ADV_KEY 8'hff
`define CMB_IDF_MIXED 2'h2

`define CMB_OFF_CTL 8'h00
`define CMB_OFF_MIER 8'h04
`define CMB_OFF_SEL 8'h08
`define CMB_OFF_MCTL 8'h0c
`define CMB_OFF_MID 8'h10
`define CMB_OFF_MDLO 8'h14
`define CMB_OFF_MDHI 8'h18
`define CMB_OFF_TXQC 8'h1c
`define CMB_OFF_RXQC 8'h20
`define CMB_OFF_TXPC 8'h24
`define CMB_OFF_RXPC 8'h28
`define CMB_OFF_MSKA 8'h2c
`define CMB_OFF_MSKB 8'h30
`define CMB_OFF_CMPA 8'h34
`define CMB_OFF_CMPB 8'h38

`define CMB_CTL_ARR 0
`define CMB_CTL_LMODE 1
`define CMB_CTL_IDF 3:2
`define CMB_CTL_OVRIE 4
`define CMB_MC_NEWD 0
`define CMB_MC_LOST 1
`define CMB_MC_ONCE 5
`define CMB_MC_RXREQ 6
`define CMB_MID_IDE 31
`define CMB_MIE_TXQ_IE 24
`define CMB_MIE_TXQ_EMPTY 25
`define CMB_MIE_RXQ_IE 28
`define CMB_MIE_RXQ_WARN 29
`define CMB_MIE_MASK 32'h3300_0000
`define CMB_QC_EN 0
`define CMB_RQC_LOST 4

`define CMB_RST_MIER 32'h0000_0000
`define CMB_RST_MASK 29'h1fff_ffff

`endif

// *** verilog/cmb_pkg.sv ***
package cmb_pkg;
   typedef struct packed {
      logic ide;
      logic [28:0] id;
      logic [63:0] data;
   } cmb_frame_t;
endpackage

// *** verilog/cmb_queue.sv ***
`timescale 1ns/100ps
module cmb_queue #(
   parameter int W = 94,
   parameter int DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic pop,
   input wire logic flush,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("queue depth must be a power of two, at least 2");
   end

   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic [W-1:0] mem_q [DEPTH];
   logic full;
   logic empty;
   logic do_pop;
   logic drop_old;

   assign count = wr_q - rd_q;
   assign full = count == (AW+1)'(DEPTH);
   assign empty = count == '0;
   assign do_pop = pop & ~empty;
   // a push into a full queue overwrites the oldest slot
   assign drop_old = push & full & ~do_pop;
   assign rdata = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (flush) begin
         rd_q <= wr_q;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (do_pop || drop_old) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (push && !flush) begin
         mem_q[wr_q[AW-1:0]] <= wdata;
      end
   end
endmodule // cmb_queue

// *** verif/cmb_mailbox_properties.sv ***
`timescale 1ns/100ps
module cmb_mailbox_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic tx_done,
   input wire logic tx_valid,
   input wire cmb_pkg::cmb_frame_t tx_frame,
   input wire logic overrun_irq,
   input wire logic txq_irq,
   input wire logic rxq_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("access not answered after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   read_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   overrun_cause_a: assert property (overrun_irq |-> $past(rx_valid))
      else $error("overrun pulse without a frame");
   rxq_cause_a: assert property (rxq_irq |-> $past(rx_valid))
      else $error("rx queue pulse without a frame");
   txq_cause_a: assert property (txq_irq |-> $past(tx_done) && $past(tx_valid))
      else $error("tx queue pulse without completion");
   pop_drop_a: assert property (tx_done && tx_valid |=> !tx_valid)
      else $error("head not released after completion");
   frame_hold_a: assert property (tx_valid && !tx_done |=> !tx_valid || $stable(tx_frame))
      else $error("queue head changed while offered");
endmodule // cmb_mailbox_properties

// *** verif/cmb_engine_model.sv ***
`timescale 1ns/100ps
module cmb_engine_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tx_valid,
   input wire logic stall,
   input wire logic slow,
   output logic tx_busy,
   output logic tx_done,
   output logic tx_abandon,
   output logic halt_enter,
   output logic rx_valid,
   output cmb_pkg::cmb_frame_t rx_frame
);
   int cnt;
   logic tried;
   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
      halt_enter = 1'b0;
   end
   // idle frame lines show the inverse so a stale value never matches
   task automatic send(input cmb_pkg::cmb_frame_t f);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_frame <= f;
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_frame <= ~f;
   endtask
   // slow mode loses the first attempt, as a busy bus would
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         tx_busy <= 1'b0;
         tx_done <= 1'b0;
         tx_abandon <= 1'b0;
         tried <= 1'b0;
      end else begin
         tx_done <= 1'b0;
         tx_abandon <= 1'b0;
         if (tx_busy) begin
            cnt <= cnt - 1;
            if (cnt == 0) begin
               tx_busy <= 1'b0;
               tx_abandon <= slow && !tried;
               tx_done <= !(slow && !tried);
               tried <= slow && !tried;
            end
         end else if (tx_valid && !stall && !tx_done && !tx_abandon) begin
            tx_busy <= 1'b1;
            cnt <= slow ? 12 : 1;
         end
      end
   end
endmodule // cmb_engine_model

// *** verif/can_mailbox_receive_and_fifo_bench.sv ***
`timescale 1ns/100ps
module can_mailbox_receive_and_fifo_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, slow = 1'b0, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rx_valid, tx_busy, tx_done, tx_abandon, halt_enter, tx_valid;
   logic overrun_irq, txq_irq, rxq_irq;
   logic [28:0] id;
   logic [31:0] d [0:4];
   cmb_pkg::cmb_frame_t rx_frame, tx_frame;
   cmb_pkg::cmb_frame_t exp_q[$];
   int num_errors = 0, n_compared = 0, cyc = 0, n_ovr = 0, n_txi = 0, n_rxi = 0;
   always #5 pclk = ~pclk;
   cmb_mailbox uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_busy(tx_busy), .tx_done(tx_done),
      .tx_abandon(tx_abandon), .halt_enter(halt_enter), .tx_valid(tx_valid), .tx_frame(tx_frame),
      .overrun_irq(overrun_irq), .txq_irq(txq_irq), .rxq_irq(rxq_irq));
   cmb_engine_model eng (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .stall(stall),
      .slow(slow), .tx_busy(tx_busy), .tx_done(tx_done), .tx_abandon(tx_abandon),
      .halt_enter(halt_enter), .rx_valid(rx_valid), .rx_frame(rx_frame));
   task automatic summarize();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench timeout ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   // pushes beyond four are expected to vanish
   task automatic push(input int n);
      for (int i = 0; i < n; i++) begin
         d[4] = $urandom();
         wr(8'h14, d[4]);
         wr(8'h24, 32'hff);
         if (i < 4) exp_q.push_back({1'b0, id, 32'h0, d[4]});
      end
   endtask
   task automatic drain();
      for (int k = 0; k < 300 && exp_q.size() > 0; k++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      rdc(8'h1c, 32'h3, "tx empty");
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (overrun_irq === 1'b1) n_ovr++;
      if (txq_irq === 1'b1) n_txi++;
      if (rxq_irq === 1'b1) n_rxi++;
      if (tx_done === 1'b1 && tx_valid === 1'b1 && exp_q.size() > 0) chk(tx_frame, exp_q.pop_front(), "tx order");
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   initial begin
      rd = $urandom(32'h80717c8d);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h04, 32'h0, "mier reset");
      rdc(8'h2c, 32'h1fffffff, "mask reset");
      apb(1'b0, 8'h3c, 32'h0);
      chk(er, 1'b1, "unmapped");
      d[0] = $urandom();
      wr(8'h04, d[0]);
      rdc(8'h04, d[0] & 32'h33000000, "mier rw");
      id = $urandom();
      // policy overwrite, overrun, then one-shot under overwrite
      for (int p = 0; p < 3; p++) begin
         wr(8'h00, p == 1 ? 32'h12 : 32'h10);
         wr(8'h08, 32'h5);
         wr(8'h0c, 32'h0);
         wr(8'h10, {3'b0, id});
         wr(8'h0c, p == 2 ? 32'h60 : 32'h40);
         n_ovr = 0;
         d[2] = $urandom();
         d[3] = $urandom();
         eng.send({1'b0, id, 32'h0, d[2]});
         eng.send({1'b0, id, 32'h0, d[3]});
         rdc(8'h14, p == 0 ? d[3] : d[2], "stored data");
         rdc(8'h0c, p == 2 ? 32'h61 : 32'h43, "mctl flags");
         chk(n_ovr, p == 1, "overrun irq");
      end
      wr(8'h0c, 32'h20);
      eng.send({1'b0, id, 32'h0, d[2]});
      rdc(8'h0c, 32'h20, "abort");
      wr(8'h0c, 32'h0);
      // mixed format: a frame whose extended bit differs must not land
      wr(8'h00, 32'h8);
      wr(8'h0c, 32'h40);
      eng.send({1'b1, id, 32'h0, d[3]});
      rdc(8'h0c, 32'h40, "mixed ide");
      wr(8'h0c, 32'h0);
      wr(8'h00, 32'h13);
      wr(8'h04, 32'h01000000);
      wr(8'h1c, 32'h1);
      wr(8'h08, 32'd56);
      wr(8'h10, {3'b0, id});
      rdc(8'h1c, 32'h3, "tx idle");
      stall <= 1'b1;
      push(5);
      rdc(8'h1c, 32'h5, "tx full");
      n_txi = 0;
      stall <= 1'b0;
      drain();
      chk(n_txi, 4, "tx every");
      wr(8'h04, 32'h03000000);
      stall <= 1'b1;
      push(3);
      n_txi = 0;
      stall <= 1'b0;
      drain();
      chk(n_txi, 1, "tx on empty");
      slow <= 1'b1;
      push(2);
      for (int k = 0; k < 50 && tx_busy !== 1'b1; k++) @(posedge pclk);
      wr(8'h1c, 32'h0);
      for (int k = 0; k < 30 && rd !== 32'h2; k++) apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h2, "abort empty");
      chk(tx_valid, 1'b0, "abort idle");
      exp_q.delete();
      wr(8'h34, {3'b0, id});
      wr(8'h20, 32'h1);
      wr(8'h04, 32'h30000000);
      n_rxi = 0;
      n_ovr = 0;
      for (int i = 0; i < 5; i++) begin
         d[i] = $urandom();
         eng.send({1'b0, id, 32'h0, d[i]});
      end
      rdc(8'h20, 32'h19, "rx full lost");
      chk(n_ovr, 1, "rx overrun");
      wr(8'h08, 32'd60);
      rdc(8'h14, d[0], "rx head");
      wr(8'h28, 32'hff);
      rdc(8'h14, d[1], "rx next");
      eng.send({1'b0, id ^ 29'h1, 32'h0, d[0]});
      rdc(8'h20, 32'h15, "rx warn");
      chk(n_rxi, 1, "warn irq");
      wr(8'h04, 32'h10000000);
      n_rxi = 0;
      eng.send({1'b0, id, 32'h0, d[2]});
      rdc(8'h20, 32'h19, "rx refill");
      chk(n_rxi, 1, "rx every");
      summarize();
   end
endmodule // can_mailbox_receive_and_fifo_bench
bind cmb_mailbox cmb_mailbox_properties chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
   .tx_done(tx_done), .tx_valid(tx_valid), .tx_frame(tx_frame), .overrun_irq(overrun_irq),
   .txq_irq(txq_irq), .rxq_irq(rxq_irq));
